// [verilog/wrls_pkg.sv]
// package: constants, state codes and timing for the watchdog, reset and limp supervisor
// What this block does
// (R1) Timeout watchdog restarts on trigger; overflow sets cyclic flag, or resets if pending.
// (R2) Timeout behaviour: disable pin low and Standby with mode bit 0 or Normal with 1.
// (R3) Watchdog off in Off, Overtemp, Sleep, Standby with mode bit 1, or pin high.
// (R4) Reset on window overflow, early window trigger, timeout overflow with flag pending.
// (R5) Reset when mode bit changes in Normal or the disable pin changes.
// (R6) Sleep request turns into reset if interrupt low, wake pending or no wake source.
// (R7) Writing 1 to the software reset bit resets the system.
// (R8) Reset pin held low by the host for the filter time is a reset request.
// (R9) Every internally triggered reset drives a low pulse on the reset pin.
// (R10) Undervoltage or leaving Off/Overtemp: short pulse with pull-up detected, else long.
// (R11) All other internally triggered reset causes use the short pulse; a host reset request drives no pulse.
// (R12) Enable output high only with its control bit set and mode field 10 or 11.
// (R13) Enable control bit writable in Normal and Standby; any reset forces it low.
// (R14) Reset sets limp warning; if already set, sets limp activate bit instead.
// (R15) Software should clear the limp warning after every reset.
// (R16) Limp activate held in Overtemp; elsewhere software may clear it.
// (R17) Limp output is active-low open drain, pulled low while activate bit is set.
// (R18) Power-off enters Off; power-on moves to Standby and sets power-on status.
// (R19) Main supply reset at 90 or 70 percent by select; warning at 90; status bit.
// (R20) CAN supply warning below 90 percent, raised in Normal only; status valid in Normal, else reads 1.
// (R21) CAN supply regulator follows the mode field; off at field value 10.
// (R22) Any watchdog register write is a trigger restarting the watchdog timer; here only i_wd_write restarts it, not period or behaviour writes.
// (R23) After a watchdog reset, period field reloads to default 100.
// (R24) Coinciding causes give one pulse; long if any cause eligible and no pull-up.
package wrls_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int FLTR_TIME_NS = 10000;
  localparam int FLTR_CYC = (FLTR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_UNIT_MS = 8;
  localparam int WD_UNIT_CYC = WD_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RST_SHORT_MS = 20;
  localparam int RST_SHORT_CYC = RST_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int RST_LONG_MS = 100;
  localparam int RST_LONG_CYC = RST_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int CW = 24;
  localparam int FW = 8;
  localparam logic [1:0] MC_STBY = 2'h0;
  localparam logic [1:0] MC_SLEEP = 2'h1;
  localparam logic [1:0] MC_NORM_V2OFF = 2'h2;
  localparam logic [1:0] MC_NORM = 2'h3;
  localparam logic [2:0] NWP_DEFAULT = 3'h4;
  // pin synchroniser lanes
  localparam int SY_WATCHDOG_DISABLE_PIN = 0;
  localparam int SY_SYSTEM_RESET_PIN_N = 1;
  localparam int SY_POFF = 2;
  localparam int SY_PON = 3;
  localparam int SY_OT = 4;
  localparam int SY_V1_90 = 5;
  localparam int SY_V1_70 = 6;
  localparam int SY_V2_90 = 7;
  localparam int SY_PU = 8;
  localparam int SY_N = 9;
  localparam logic [SY_N-1:0] SY_RST_VAL = 9'h002;
  localparam logic [1:0] WARM_DONE = 2'h3;
  localparam int IRQ_POWER_ON_STATUS_IRQ = 0;
  localparam int IRQ_V1 = 1;
  localparam int IRQ_V2 = 2;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_STBY = 5'h02,
    ST_NORM = 5'h04,
    ST_SLEEP = 5'h08,
    ST_OT = 5'h10
  } wrls_state_t;
endpackage

// [verilog/wrls_rst_pulse.sv]
// reset pulse generator: short or long low pulse on the reset pin
`timescale 1ns/1ps
`default_nettype none
module wrls_rst_pulse #(
  parameter logic [wrls_pkg::CW-1:0] P_SHORT_CYC = wrls_pkg::CW'(wrls_pkg::RST_SHORT_CYC),
  parameter logic [wrls_pkg::CW-1:0] P_LONG_CYC = wrls_pkg::CW'(wrls_pkg::RST_LONG_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_start,
  input wire logic i_long,
  output logic o_active
);
  logic [wrls_pkg::CW-1:0] cnt_r;
  logic [wrls_pkg::CW-1:0] cnt_nxt;
  wire [wrls_pkg::CW-1:0] width = i_long ? P_LONG_CYC : P_SHORT_CYC;

  // a new cause during a pulse restarts it with its own width
  assign cnt_nxt = i_start ? width : (cnt_r != '0) ? cnt_r - 1'b1 : cnt_r; // see (R9)
  assign o_active = cnt_r != '0;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  a_pulse_start: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_start |=> o_active [*8]) else $error("reset pulse not started"); // see (R9)
  a_pulse_width: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_start && i_long |=> cnt_r == P_LONG_CYC) else $error("long width wrong"); // see (R10)
endmodule
`default_nettype wire

// [verilog/wrls_supervisor.sv]
// supervisor top: chip modes, watchdog, reset sources, enable and limp outputs
`timescale 1ns/1ps
`default_nettype none
module wrls_supervisor #(
  parameter logic [wrls_pkg::CW-1:0] P_WD_UNIT_CYC = wrls_pkg::CW'(wrls_pkg::WD_UNIT_CYC),
  parameter logic [wrls_pkg::CW-1:0] P_SHORT_CYC = wrls_pkg::CW'(wrls_pkg::RST_SHORT_CYC),
  parameter logic [wrls_pkg::CW-1:0] P_LONG_CYC = wrls_pkg::CW'(wrls_pkg::RST_LONG_CYC)
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_watchdog_disable_pin,
  input wire logic i_system_reset_pin_n,
  input wire logic i_power_off_det,
  input wire logic i_power_on_det,
  input wire logic i_overtemp,
  input wire logic i_v1_below_90,
  input wire logic i_v1_below_70,
  input wire logic i_v2_below_90,
  input wire logic i_short_pullup_det,
  input wire logic i_interrupt_out_n,
  input wire logic i_wake_pending,
  input wire logic i_can_standby_control,
  input wire logic i_lin_first_standby_control,
  input wire logic i_lin_second_standby_control,
  input wire logic [1:0] i_wake_input_first_config,
  input wire logic [1:0] i_wake_input_second_config,
  input wire logic i_reset_threshold_select,
  input wire logic i_wd_write,
  input wire logic i_period_wr,
  input wire logic [2:0] i_period_data,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_mode_data,
  input wire logic i_behaviour_wr,
  input wire logic i_behaviour_data,
  input wire logic i_enable_ctrl_wr,
  input wire logic i_enable_ctrl_data,
  input wire logic i_software_reset_bit,
  input wire logic i_limp_warning_clr,
  input wire logic i_limp_activate_clr,
  input wire logic i_cyclic_clr,
  input wire logic [2:0] i_irq_clr,
  output logic o_system_reset_pin_n_out,
  output logic o_system_reset_pin_n_oe,
  output logic o_limp_out,
  output logic o_limp_oe,
  output logic o_enable_out,
  output logic o_can_supply_enable,
  output logic [1:0] o_chip_mode_field,
  output logic [4:0] o_chip_state,
  output logic [2:0] o_watchdog_period_field,
  output logic o_watchdog_behaviour_select,
  output logic o_enable_output_control,
  output logic o_limp_warning_bit,
  output logic o_limp_activate_bit,
  output logic o_cyclic_interrupt_flag,
  output logic o_power_on_status_irq,
  output logic o_main_supply_undervolt_irq,
  output logic o_can_supply_undervolt_irq,
  output logic o_main_supply_status,
  output logic o_can_supply_status
);
  typedef wrls_pkg::wrls_state_t st_t;
  localparam int CW = wrls_pkg::CW;
  localparam int FW = wrls_pkg::FW;
  localparam logic [FW-1:0] FLTR = FW'(wrls_pkg::FLTR_CYC);

  function automatic logic [CW-1:0] wd_period(input logic [2:0] f);
    wd_period = P_WD_UNIT_CYC << f;
  endfunction

  logic [wrls_pkg::SY_N-1:0] sy1_r, sy2_r, sy3_r;
  logic [1:0] warm_r;
  st_t st_r, st_nxt;
  logic [1:0] mc_r, mc_nxt;
  logic [2:0] nwp_r, nwp_nxt;
  logic wmc_r, wmc_nxt, enc_r, enc_nxt, limp_warning_bit_r, limp_warning_bit_nxt, lhc_r, lhc_nxt;
  logic ci_r, ci_nxt;
  logic [2:0] irq_r, irq_nxt;
  logic [CW-1:0] wd_cnt_r, wd_cnt_nxt;
  logic [FW-1:0] ext_cnt_r;
  logic [2:0] oe_dly_r;
  logic pulse_act;

  // synchronised pin levels and their changes
  wire warm = warm_r == wrls_pkg::WARM_DONE;
  wire watchdog_disable_pin = sy2_r[wrls_pkg::SY_WATCHDOG_DISABLE_PIN];
  wire system_reset_pin_n_s = sy2_r[wrls_pkg::SY_SYSTEM_RESET_PIN_N];
  wire poff = sy2_r[wrls_pkg::SY_POFF];
  wire pon = sy2_r[wrls_pkg::SY_PON];
  wire ot = sy2_r[wrls_pkg::SY_OT];
  wire v1_90 = sy2_r[wrls_pkg::SY_V1_90];
  wire v2_90 = sy2_r[wrls_pkg::SY_V2_90];
  wire pu_short = sy2_r[wrls_pkg::SY_PU];
  wire [wrls_pkg::SY_N-1:0] rise = sy2_r & ~sy3_r & {wrls_pkg::SY_N{warm}};
  wire [wrls_pkg::SY_N-1:0] chg = (sy2_r ^ sy3_r) & {wrls_pkg::SY_N{warm}};

  wire in_off = st_r == wrls_pkg::ST_OFF;
  wire in_stby = st_r == wrls_pkg::ST_STBY;
  wire in_norm = st_r == wrls_pkg::ST_NORM;
  wire in_sleep = st_r == wrls_pkg::ST_SLEEP;
  wire in_ot = st_r == wrls_pkg::ST_OT;
  wire run = in_stby || in_norm;

  // watchdog behaviour decode
  wire wd_tmo = !watchdog_disable_pin && ((in_stby && !wmc_r) || (in_norm && wmc_r)); // see (R2)
  wire wd_win = !watchdog_disable_pin && in_norm && !wmc_r;
  wire wd_off = !wd_tmo && !wd_win; // see (R3)
  wire [CW-1:0] period = wd_period(nwp_r);
  wire wd_ovf = !wd_off && !i_wd_write && wd_cnt_r == period - 1'b1;
  wire early = wd_win && i_wd_write && wd_cnt_r < (period >> 1);
  wire tmo_ovf = wd_tmo && wd_ovf;
  wire wmc_ok = i_behaviour_wr && !(in_stby && !i_interrupt_out_n);
  wire wmc_chg = wmc_ok && in_norm && i_behaviour_data != wmc_r;
  wire wd_rst = (wd_win && wd_ovf) || early || (tmo_ovf && ci_r); // see (R4)
  wire mode_rst = wmc_chg || (chg[wrls_pkg::SY_WATCHDOG_DISABLE_PIN] && !in_off); // see (R5)

  // sleep request that must become a reset instead
  wire no_wake_src = !i_can_standby_control && !i_lin_first_standby_control &&
    !i_lin_second_standby_control && i_wake_input_first_config == 2'h0 &&
    i_wake_input_second_config == 2'h0;
  wire sleep_req = run && i_mode_wr && i_mode_data == wrls_pkg::MC_SLEEP;
  wire sleep_bad = !i_interrupt_out_n || i_wake_pending || no_wake_src;
  wire sleep_rst = sleep_req && sleep_bad; // see (R6)

  // supply events
  wire uv_sel = i_reset_threshold_select ? sy2_r[wrls_pkg::SY_V1_70] : v1_90;
  wire uv_rst = !in_off && uv_sel && (i_reset_threshold_select ?
    rise[wrls_pkg::SY_V1_70] : rise[wrls_pkg::SY_V1_90]); // see (R19)
  wire leave_off = in_off && !poff && pon;
  wire leave_ot = in_ot && !poff && !ot;

  // reset causes combined into one pulse
  wire long_elig = uv_rst || leave_off || leave_ot; // see (R10)
  wire short_rst = !in_off && (wd_rst || mode_rst || sleep_rst || i_software_reset_bit); // see (R7)
  wire pulse_start = long_elig || short_rst; // see (R11)
  wire pulse_long = long_elig && !pu_short; // see (R24)

  // host reset request: our own drive and its echo are masked
  wire ext_mask = pulse_act || (oe_dly_r != 3'h0) || !warm;
  wire ext_low = !system_reset_pin_n_s && !ext_mask;
  wire ext_rst = ext_low && ext_cnt_r == FLTR - 1'b1; // see (R8)
  wire sys_rst = pulse_start || ext_rst;

  // chip mode sequencing
  always_comb begin
    st_nxt = st_r;
    mc_nxt = mc_r;
    if (poff) begin
      st_nxt = wrls_pkg::ST_OFF; // see (R18)
      mc_nxt = wrls_pkg::MC_STBY;
    end else if (in_off) begin
      if (pon) begin
        st_nxt = wrls_pkg::ST_STBY;
      end
    end else if (in_ot) begin
      if (!ot) begin
        st_nxt = wrls_pkg::ST_STBY;
        mc_nxt = wrls_pkg::MC_STBY;
      end
    end else if (ot) begin
      st_nxt = wrls_pkg::ST_OT;
    end else if (sys_rst) begin
      st_nxt = wrls_pkg::ST_STBY;
      mc_nxt = wrls_pkg::MC_STBY;
    end else if (in_sleep) begin
      if (i_wake_pending) begin
        st_nxt = wrls_pkg::ST_STBY;
        mc_nxt = wrls_pkg::MC_STBY;
      end
    end else if (i_mode_wr) begin
      mc_nxt = i_mode_data;
      case (i_mode_data)
        wrls_pkg::MC_STBY: st_nxt = wrls_pkg::ST_STBY;
        wrls_pkg::MC_SLEEP: st_nxt = wrls_pkg::ST_SLEEP;
        default: st_nxt = wrls_pkg::ST_NORM;
      endcase
    end
  end

  // control bits; hardware sets win over software clears
  assign nwp_nxt = wd_rst || mode_rst ? wrls_pkg::NWP_DEFAULT :
    i_period_wr ? i_period_data : nwp_r; // see (R23)
  assign wmc_nxt = wmc_ok ? i_behaviour_data : wmc_r;
  assign enc_nxt = sys_rst ? 1'b0 : (i_enable_ctrl_wr && run) ? i_enable_ctrl_data : enc_r; // see (R13)
  assign limp_warning_bit_nxt = sys_rst || (limp_warning_bit_r && !i_limp_warning_clr); // see (R14)
  assign lhc_nxt = (sys_rst && limp_warning_bit_r) || in_ot || (lhc_r && !i_limp_activate_clr); // see (R16)
  assign ci_nxt = (tmo_ovf && !ci_r) || (ci_r && !i_cyclic_clr); // see (R1)
  assign irq_nxt[wrls_pkg::IRQ_POWER_ON_STATUS_IRQ] = leave_off || (irq_r[wrls_pkg::IRQ_POWER_ON_STATUS_IRQ] &&
    !i_irq_clr[wrls_pkg::IRQ_POWER_ON_STATUS_IRQ]); // see (R18)
  assign irq_nxt[wrls_pkg::IRQ_V1] = (!in_off && rise[wrls_pkg::SY_V1_90]) ||
    (irq_r[wrls_pkg::IRQ_V1] && !i_irq_clr[wrls_pkg::IRQ_V1]); // see (R19)
  assign irq_nxt[wrls_pkg::IRQ_V2] = (in_norm && rise[wrls_pkg::SY_V2_90]) ||
    (irq_r[wrls_pkg::IRQ_V2] && !i_irq_clr[wrls_pkg::IRQ_V2]); // see (R20)
  assign wd_cnt_nxt = (wd_off || i_wd_write || wd_ovf || sys_rst) ? '0 :
    wd_cnt_r + 1'b1; // see (R22)

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sy1_r <= wrls_pkg::SY_RST_VAL;
      sy2_r <= wrls_pkg::SY_RST_VAL;
      sy3_r <= wrls_pkg::SY_RST_VAL;
      warm_r <= 2'h0;
    end else begin
      sy1_r <= {i_short_pullup_det, i_v2_below_90, i_v1_below_70, i_v1_below_90,
        i_overtemp, i_power_on_det, i_power_off_det, i_system_reset_pin_n,
        i_watchdog_disable_pin};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      warm_r <= warm ? warm_r : warm_r + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      st_r <= wrls_pkg::ST_OFF;
      mc_r <= wrls_pkg::MC_STBY;
      nwp_r <= wrls_pkg::NWP_DEFAULT;
      wmc_r <= 1'b0;
      enc_r <= 1'b0;
      limp_warning_bit_r <= 1'b0;
      lhc_r <= 1'b0;
      ci_r <= 1'b0;
      irq_r <= 3'h0;
    end else begin
      st_r <= st_nxt;
      mc_r <= mc_nxt;
      nwp_r <= nwp_nxt;
      wmc_r <= wmc_nxt;
      enc_r <= enc_nxt;
      limp_warning_bit_r <= limp_warning_bit_nxt;
      lhc_r <= lhc_nxt;
      ci_r <= ci_nxt;
      irq_r <= irq_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wd_cnt_r <= '0;
      ext_cnt_r <= '0;
      oe_dly_r <= 3'h0;
    end else begin
      wd_cnt_r <= wd_cnt_nxt;
      ext_cnt_r <= ext_low ? (ext_cnt_r == FLTR ? ext_cnt_r : ext_cnt_r + 1'b1) : '0;
      oe_dly_r <= {oe_dly_r[1:0], pulse_act};
    end
  end

  wrls_rst_pulse #(
    .P_SHORT_CYC(P_SHORT_CYC),
    .P_LONG_CYC(P_LONG_CYC)
  ) u_pulse (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_start(pulse_start),
    .i_long(pulse_long),
    .o_active(pulse_act)
  );

  // open-drain pins: only ever pulled low
  assign o_system_reset_pin_n_out = 1'b0;
  assign o_system_reset_pin_n_oe = pulse_act; // see (R9)
  assign o_limp_out = 1'b0;
  assign o_limp_oe = lhc_r; // see (R17)
  assign o_enable_out = enc_r && mc_r[1] && in_norm; // see (R12)
  assign o_can_supply_enable = in_norm && mc_r == wrls_pkg::MC_NORM; // see (R21)
  assign o_chip_mode_field = mc_r;
  assign o_chip_state = st_r;
  assign o_watchdog_period_field = nwp_r;
  assign o_watchdog_behaviour_select = wmc_r;
  assign o_enable_output_control = enc_r;
  assign o_limp_warning_bit = limp_warning_bit_r;
  assign o_limp_activate_bit = lhc_r;
  assign o_cyclic_interrupt_flag = ci_r;
  assign o_power_on_status_irq = irq_r[wrls_pkg::IRQ_POWER_ON_STATUS_IRQ];
  assign o_main_supply_undervolt_irq = irq_r[wrls_pkg::IRQ_V1];
  assign o_can_supply_undervolt_irq = irq_r[wrls_pkg::IRQ_V2];
  assign o_main_supply_status = !v1_90; // see (R19)
  assign o_can_supply_status = in_norm ? !v2_90 : 1'b1; // see (R20)

  a_ci_first_ovf: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R1)
    tmo_ovf && !ci_r |=> ci_r && wd_cnt_r == '0) else $error("cyclic flag not set");
  a_ci_pending_rst: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R4)
    tmo_ovf && ci_r && !in_off |=> o_system_reset_pin_n_oe) else $error("no reset on overflow");
  a_wd_off_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R3)
    (watchdog_disable_pin || in_sleep || in_ot) |=> wd_cnt_r == '0) else $error("watchdog ran while off");
  a_trig_restart: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R22)
    i_wd_write |=> wd_cnt_r == '0) else $error("trigger did not restart timer");
  a_wmc_change_rst: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R5)
    wmc_chg |=> o_system_reset_pin_n_oe && !o_enable_out) else $error("mode bit change no reset");
  a_sleep_reject: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R6)
    sleep_req && sleep_bad && !poff && !ot |=> !in_sleep && o_system_reset_pin_n_oe)
    else $error("bad sleep entered");
  a_swr_reset: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R7)
    i_software_reset_bit && !in_off |=> o_system_reset_pin_n_oe [*3])
    else $error("software reset missing");
  a_ext_filter: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R8)
    ext_rst |-> !system_reset_pin_n_s && !$past(system_reset_pin_n_s, FLTR - 1'b1)) else $error("filter count wrong");
  a_en_reset_low: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R13)
    sys_rst |=> !o_enable_out && !enc_r) else $error("enable not cleared by reset");
  a_limp_escalate: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R14)
    sys_rst && limp_warning_bit_r |=> lhc_r && o_limp_oe) else $error("limp not activated");
  a_limp_overtemp: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R16)
    in_ot |=> o_limp_activate_bit) else $error("limp released in overtemp");
  a_power_on_status_irq_leave_off: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R18)
    leave_off |=> in_stby && o_power_on_status_irq) else $error("power-on not reported");
  a_period_reload: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R23)
    wd_rst |=> nwp_r == wrls_pkg::NWP_DEFAULT) else $error("period not reloaded");
  a_v2_status_idle: assert property (@(posedge i_clock) disable iff (!i_rst_b) // see (R20)
    !in_norm |-> o_can_supply_status) else $error("can supply status not 1");
endmodule
`default_nettype wire

// [sim/wrls_host_model.sv]
// host side model: reset wire with pull-up, driven by the device and by the host
`timescale 1ns/1ps
`default_nettype none
module wrls_host_model (
  input wire logic i_hold_low,
  input wire logic i_dev_out,
  input wire logic i_dev_oe,
  output logic o_pin_n
);
  // the wire has a pull-up, so it reads high whenever nobody pulls it down
  assign o_pin_n = ~i_hold_low & (~i_dev_oe | i_dev_out);
endmodule
`default_nettype wire

// [sim/wrls_supervisor_test.sv]
// testbench for the watchdog, reset and limp supervisor
`timescale 1ns/1ps
`default_nettype none
module wrls_supervisor_test;
  localparam logic [23:0] UNIT_C = 24'h8;
  localparam logic [23:0] SHORT_C = 24'hA;
  localparam logic [23:0] LONG_C = 24'h1E;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_watchdog_disable_pin = 1'b1;
  logic host_hold = 1'b0;
  logic i_power_on_det = 1'b0, i_v1_below_90 = 1'b0, i_v2_below_90 = 1'b0;
  logic i_power_off_det = 1'b0, i_v1_below_70 = 1'b0, i_overtemp = 1'b0;
  logic i_interrupt_out_n = 1'b1, i_wake_pending = 1'b0, i_can_standby_control = 1'b0;
  logic i_reset_threshold_select = 1'b0, i_behaviour_wr = 1'b0, i_behaviour_data = 1'b0;
  logic i_short_pullup_det = 1'b0;
  logic i_wd_write = 1'b0, i_period_wr = 1'b0, i_mode_wr = 1'b0, i_enable_ctrl_wr = 1'b0;
  logic i_software_reset_bit = 1'b0, i_limp_warning_clr = 1'b0, i_limp_activate_clr = 1'b0;
  logic i_cyclic_clr = 1'b0;
  logic [2:0] i_irq_clr = 3'h0, i_period_data = 3'h4;
  logic [1:0] i_mode_data = 2'h0;
  logic i_enable_ctrl_data = 1'b0;
  logic pin_n, rst_out, rst_oe, limp_out, limp_oe, en_out, can_en, enable_output_control, limp_warning_bit, limp_activate_bit, ci, power_on_status_irq;
  logic v1_irq, v2_irq, v1_stat, v2_stat, watchdog_behaviour_select;
  logic [1:0] mc;
  logic [4:0] state;
  logic [2:0] period;
  int err_total = 0;
  int checked = 0;

  always #50 i_clock = ~i_clock;

  wrls_host_model u_wrls_host_model (.i_hold_low(host_hold), .i_dev_out(rst_out),
    .i_dev_oe(rst_oe), .o_pin_n(pin_n));

  wrls_supervisor #(.P_WD_UNIT_CYC(UNIT_C), .P_SHORT_CYC(SHORT_C), .P_LONG_CYC(LONG_C))
  u_wrls_supervisor (.i_clock(i_clock), .i_rst_b(i_rst_b),
    .i_watchdog_disable_pin(i_watchdog_disable_pin), .i_system_reset_pin_n(pin_n),
    .i_power_off_det(i_power_off_det), .i_power_on_det(i_power_on_det),
    .i_overtemp(i_overtemp), .i_v1_below_90(i_v1_below_90), .i_v1_below_70(i_v1_below_70),
    .i_v2_below_90(i_v2_below_90), .i_short_pullup_det(i_short_pullup_det),
    .i_interrupt_out_n(i_interrupt_out_n), .i_wake_pending(i_wake_pending),
    .i_can_standby_control(i_can_standby_control),
    .i_lin_first_standby_control(1'b0), .i_lin_second_standby_control(1'b0),
    .i_wake_input_first_config(2'h0), .i_wake_input_second_config(2'h0),
    .i_reset_threshold_select(i_reset_threshold_select), .i_wd_write(i_wd_write),
    .i_period_wr(i_period_wr),
    .i_period_data(i_period_data), .i_mode_wr(i_mode_wr), .i_mode_data(i_mode_data),
    .i_behaviour_wr(i_behaviour_wr), .i_behaviour_data(i_behaviour_data),
    .i_enable_ctrl_wr(i_enable_ctrl_wr),
    .i_enable_ctrl_data(i_enable_ctrl_data), .i_software_reset_bit(i_software_reset_bit),
    .i_limp_warning_clr(i_limp_warning_clr), .i_limp_activate_clr(i_limp_activate_clr),
    .i_cyclic_clr(i_cyclic_clr), .i_irq_clr(i_irq_clr),
    .o_system_reset_pin_n_out(rst_out), .o_system_reset_pin_n_oe(rst_oe),
    .o_limp_out(limp_out), .o_limp_oe(limp_oe), .o_enable_out(en_out),
    .o_can_supply_enable(can_en), .o_chip_mode_field(mc), .o_chip_state(state),
    .o_watchdog_period_field(period), .o_watchdog_behaviour_select(watchdog_behaviour_select),
    .o_enable_output_control(enable_output_control), .o_limp_warning_bit(limp_warning_bit), .o_limp_activate_bit(limp_activate_bit),
    .o_cyclic_interrupt_flag(ci), .o_power_on_status_irq(power_on_status_irq),
    .o_main_supply_undervolt_irq(v1_irq), .o_can_supply_undervolt_irq(v2_irq),
    .o_main_supply_status(v1_stat), .o_can_supply_status(v2_stat));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  // one-cycle write strobe: 0 trigger 1 mode 2 enable 3 sw reset 4/5 limp clears
  // 6 cyclic clear 7 period 8 irq clear 9 behaviour select
  task automatic wr(input int k, input logic [2:0] d);
    @(negedge i_clock);
    case (k)
      0: i_wd_write = 1'b1;
      1: i_mode_wr = 1'b1;
      2: i_enable_ctrl_wr = 1'b1;
      3: i_software_reset_bit = 1'b1;
      4: i_limp_warning_clr = 1'b1;
      5: i_limp_activate_clr = 1'b1;
      6: i_cyclic_clr = 1'b1;
      7: i_period_wr = 1'b1;
      9: i_behaviour_wr = 1'b1;
      default: i_irq_clr = d;
    endcase
    i_behaviour_data = d[0];
    i_mode_data = d[1:0];
    i_enable_ctrl_data = d[0];
    i_period_data = d;
    @(negedge i_clock);
    {i_wd_write, i_mode_wr, i_enable_ctrl_wr, i_software_reset_bit, i_period_wr} = '0;
    {i_limp_warning_clr, i_limp_activate_clr, i_cyclic_clr, i_behaviour_wr} = '0;
    i_irq_clr = 3'h0;
  endtask

  // waits for the device to pull the reset wire, then counts its low cycles
  task automatic pulse_len(output int n);
    int w;
    w = 0;
    n = 0;
    while (rst_oe !== 1'b1 && w < 400) begin
      @(negedge i_clock);
      w++;
    end
    while (rst_oe === 1'b1 && n < 2000) begin
      @(negedge i_clock);
      n++;
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(100 * 20000);
    err_total++;
    $display("wrong value at %0t: run did not finish", $time);
    end_of_test;
  end

  initial begin
    int n;
    cyc(2);
    i_rst_b = 1'b1;
    chk(state, 5'h01);
    chk(period, 3'h4);
    chk(rst_oe, 1'b0);
    cyc(4);
    i_power_on_det = 1'b1;
    pulse_len(n);
    chk(n, LONG_C);
    chk(state, 5'h02);
    chk(power_on_status_irq, 1'b1);
    wr(4, 3'h0);
    wr(8, 3'h1);
    chk(power_on_status_irq, 1'b0);
    wr(3, 3'h0);
    chk({rst_oe, rst_out, pin_n}, 3'h4);
    chk(limp_warning_bit, 1'b1);
    pulse_len(n);
    chk(n, SHORT_C);
    wr(3, 3'h0);
    chk(limp_activate_bit, 1'b1);
    chk({limp_oe, limp_out}, 2'h2);
    pulse_len(n);
    wr(4, 3'h0);
    wr(5, 3'h0);
    chk(limp_oe, 1'b0);
    wr(2, 3'h1);
    wr(1, 3'h3);
    chk({state, en_out, can_en}, {5'h04, 2'h3});
    wr(1, 3'h2);
    chk({en_out, can_en}, 2'h2);
    i_v2_below_90 = 1'b1;
    cyc(4);
    chk({v2_stat, v2_irq}, 2'h1);
    wr(3, 3'h0);
    chk({en_out, enable_output_control}, 2'h0);
    pulse_len(n);
    chk({state, v2_stat}, {5'h02, 1'b1});
    wr(4, 3'h0);
    wr(1, 3'h1);
    pulse_len(n);
    chk(n, SHORT_C);
    chk(state, 5'h02);
    wr(4, 3'h0);
    cyc(4);
    host_hold = 1'b1;
    n = 0;
    repeat (120) begin
      @(negedge i_clock);
      if (rst_oe === 1'b1) n++;
    end
    host_hold = 1'b0;
    chk(n, 0);
    chk(limp_warning_bit, 1'b1);
    wr(4, 3'h0);
    i_short_pullup_det = 1'b1;
    i_v1_below_90 = 1'b1;
    pulse_len(n);
    chk(n, SHORT_C);
    chk({v1_stat, v1_irq}, 2'h1);
    i_v1_below_90 = 1'b0;
    cyc(4);
    chk(v1_stat, 1'b1);
    wr(4, 3'h0);
    i_watchdog_disable_pin = 1'b0;
    pulse_len(n);
    chk(n, SHORT_C);
    wr(7, 3'h3);
    repeat (3) begin
      cyc(40);
      wr(0, 3'h0);
      chk(ci, 1'b0);
    end
    cyc(50);
    chk(ci, 1'b0);
    cyc(20);
    chk(ci, 1'b1);
    pulse_len(n);
    chk(n, SHORT_C);
    chk(period, 3'h4);
    i_watchdog_disable_pin = 1'b1;
    pulse_len(n);
    chk(n, SHORT_C);
    wr(6, 3'h0);
    cyc(300);
    chk(ci, 1'b0);
    wr(4, 3'h0);
    wr(5, 3'h0);
    wr(1, 3'h3);
    wr(9, 3'h1);
    pulse_len(n);
    chk(n, SHORT_C);
    chk({mc, watchdog_behaviour_select}, 3'h1);
    i_interrupt_out_n = 1'b0;
    i_can_standby_control = 1'b1;
    wr(9, 3'h0);
    chk(watchdog_behaviour_select, 1'b1);
    wr(1, 3'h1);
    pulse_len(n);
    chk(n, SHORT_C);
    i_interrupt_out_n = 1'b1;
    wr(1, 3'h1);
    chk(state, 5'h08);
    i_wake_pending = 1'b1;
    cyc(2);
    chk(state, 5'h02);
    wr(1, 3'h1);
    pulse_len(n);
    chk(n, SHORT_C);
    chk(state, 5'h02);
    i_wake_pending = 1'b0;
    i_can_standby_control = 1'b0;
    wr(4, 3'h0);
    wr(5, 3'h0);
    i_overtemp = 1'b1;
    cyc(4);
    chk({state, limp_activate_bit}, {5'h10, 1'b1});
    wr(5, 3'h0);
    chk(limp_oe, 1'b1);
    i_short_pullup_det = 1'b0;
    i_overtemp = 1'b0;
    pulse_len(n);
    chk(n, LONG_C);
    chk(state, 5'h02);
    wr(5, 3'h0);
    chk(limp_activate_bit, 1'b0);
    wr(8, 3'h6);
    chk({v1_irq, v2_irq}, 2'h0);
    i_reset_threshold_select = 1'b1;
    i_v1_below_90 = 1'b1;
    cyc(6);
    chk({rst_oe, v1_stat, v1_irq}, 3'h1);
    i_v1_below_70 = 1'b1;
    pulse_len(n);
    chk(n, LONG_C);
    i_v1_below_90 = 1'b0;
    i_v1_below_70 = 1'b0;
    i_power_off_det = 1'b1;
    cyc(4);
    chk(state, 5'h01);
    i_power_off_det = 1'b0;
    pulse_len(n);
    chk(n, LONG_C);
    chk({state, power_on_status_irq}, {5'h02, 1'b1});
    end_of_test;
  end
endmodule
`default_nettype wire
